// File: hdl/acms_defs.svh
// Constants for the converter configuration-source selection block.
// Assumes one 100 MHz clock on both ends; the link pins are slow levels.
// Behaviour
// R1: Low-latency option gives ten-sample output latency.
// R2: Host holds reset pin high for pins.
// R3: Pin mode configures itself from pin levels.
// R4: Shift clock level selects gain and reference.
// R5: Select level picks interface and format.
// R6: Three mode pins jointly choose power modes.
// R7: Host holds reset low for serial port.
// R8: Reset pulse or soft bit loads defaults.
// R9: Host keeps reset low while programming.
// R10: Serial-only host ties mode pins low.
// R11: Host holds reset low for combined control.
// R12: Combined mode takes power modes from pins.
// R13: Override zero: mode pins choose power-down.
// R14: Override one: register field chooses power-down.
// R15: Falling-edge sampling, commit every sixteenth edge.
// R16: Address byte first, then data byte.
// R17: Soft reset restores defaults, self-clears.
// R18: Mode pin pattern decode table.
// R19: Shift activity ignored while reset pin high.
// R20: Analog pins seen as two-bit codes.
`ifndef ACMS_DEFS_SVH
`define ACMS_DEFS_SVH
`define ACMS_CLK_NS 10
`define ACMS_LAT_LONG 14
`define ACMS_LAT_SHORT 10
`define ACMS_WORD_BITS 16
`define ACMS_SCLK_HALF_NS 40
`define ACMS_SCLK_HALF_CYC (`ACMS_SCLK_HALF_NS / `ACMS_CLK_NS)
`define ACMS_RST_MIN_NS 10
`define ACMS_RST_SYNC_MARGIN 2
`define ACMS_RST_CYC (((`ACMS_RST_MIN_NS + `ACMS_CLK_NS - 1) / `ACMS_CLK_NS) + `ACMS_RST_SYNC_MARGIN)
// Device register addresses and fields
`define ACMS_DREG_CTRL 8'h00
`define ACMS_DREG_PWR 8'h01
`define ACMS_DREG_CFG 8'h02
`define ACMS_CTRL_SRST 0
`define ACMS_CTRL_LOWLAT 1
`define ACMS_PWR_PIN_PRIORITY_SELECT 3
`define ACMS_CFG_GAIN 0
`define ACMS_CFG_EXTREF 1
`define ACMS_CFG_CMOS 2
`define ACMS_CFG_STRAIGHT 3
`define ACMS_CTRL_DEF 8'h00
`define ACMS_PWR_DEF 8'h00
`define ACMS_CFG_DEF 8'h00
// Host command registers
`define ACMS_HREG_CTRL 3'h0
`define ACMS_HREG_LVL 3'h1
`define ACMS_HREG_WORD 3'h2
`define ACMS_HREG_STAT 3'h3
`define ACMS_HCTL_PINMODE 0
`define ACMS_HCTL_RSTPULSE 1
`define ACMS_HCTL_MODE_LSB 2
`define ACMS_HCTL_DEF 16'h0000
`define ACMS_HLVL_DEF 16'h0000
`define ACMS_LVL_HIGH 2'h3
`define ACMS_LVL_LOW 2'h0
`endif

// File: hdl/acms_pkg.sv
// Types shared by both ends of the configuration link.
// Assumes acms_defs.svh supplies the numeric constants.
package acms_pkg;
    // Encoding equals the mode pin pattern {one, two, three}
    typedef enum logic [2:0] {
        PWR_NORMAL = 3'h0,
        PWR_BUF_A_OFF = 3'h1,
        PWR_BUF_B_OFF = 3'h2,
        PWR_BUF_AB_OFF = 3'h3,
        PWR_DOWN_AB = 3'h4,
        PWR_STBY_A = 3'h5,
        PWR_STBY_B = 3'h6,
        PWR_INTERLEAVED = 3'h7
    } acms_pwr_t;
    typedef enum logic [1:0] {
        SER_OFF = 2'b01,
        SER_ACT = 2'b10
    } acms_ser_t;
    typedef enum logic [4:0] {
        HST_IDLE = 5'b00001,
        HST_SETUP = 5'b00010,
        HST_HI = 5'b00100,
        HST_LO = 5'b01000,
        HST_HOLD = 5'b10000
    } acms_hst_t;
endpackage

// File: hdl/acms_if.sv
// Pins between the host controller and the converter's control logic.
// All signals are driven by the host; analog pins carry two-bit level codes.
interface acms_if;
    logic resetPin;
    logic [1:0] selLvl;
    logic [1:0] sclkLvl;
    logic dataPin;
    logic [2:0] modePins;
    modport host (
        output resetPin,
        output selLvl,
        output sclkLvl,
        output dataPin,
        output modePins
    );
    modport dev (
        input resetPin,
        input selLvl,
        input sclkLvl,
        input dataPin,
        input modePins
    );
endinterface

// File: hdl/acms_dev.sv
// Converter control end: selects pin or serial configuration, holds the
// serial registers and delays samples by the configured latency.
// Assumes link pins are asynchronous and samples arrive with sampleTick.
`include "acms_defs.svh"
module acms_dev
    import acms_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    acms_if.dev lnk, // Configuration pins
    input wire logic sampleTick, // One pulse per conversion
    input wire logic [11:0] chanA, // Channel A sample, two's complement
    input wire logic [11:0] chanB, // Channel B sample, two's complement
    output logic [11:0] outA, // Delayed channel A data (or interleaved)
    output logic [11:0] outB, // Delayed channel B data
    output logic outValid, // Pulse when outputs update, except in PWR_DOWN_AB
    output logic outAEn, // Channel A output buffer enabled
    output logic outBEn, // Channel B output buffer enabled
    output logic gainHigh, // Coarse gain selected
    output logic extRef, // External reference selected
    output logic cmosIf, // Parallel CMOS interface, else DDR LVDS
    output logic straightBin, // Straight binary, else two's complement
    output logic lowLatency, // Low-latency option active
    output logic serialMode, // Serial configuration active
    output acms_pwr_t pwrMode // Effective power mode
);
    logic [8:0] pinRaw;
    logic [8:0] pinS1_r;
    logic [8:0] pinS2_r;
    logic rstPinD;
    logic [1:0] selD;
    logic [1:0] sclkD;
    logic dataD;
    logic [2:0] modeD;
    logic sclkPrev_r;
    logic rstPrev_r;
    logic sclkFall;
    logic hwInit;
    acms_ser_t serState_r;
    logic [3:0] bitCnt_r;
    logic [15:0] shift_r;
    logic [15:0] wordNxt;
    logic commit;
    logic [7:0] ctrlReg_r;
    logic [7:0] pwrReg_r;
    logic [7:0] cfgReg_r;
    logic pinGain;
    logic pinExt;
    logic pinCmos;
    logic pinStraight;
    logic [11:0] pipeA [0:`ACMS_LAT_LONG-1];
    logic [11:0] pipeB [0:`ACMS_LAT_LONG-1];
    logic [11:0] tapA;
    logic [11:0] tapB;
    logic muxPhase_r;

    // Splits a two-bit level code: upper bit and the exclusive-or of both bits
    function automatic logic [1:0] lvlSplit(input logic [1:0] code);
        lvlSplit = {code[1], code[1] ^ code[0]};
    endfunction

    function automatic logic [11:0] fmtConv(input logic [11:0] s, input logic sb);
        fmtConv = sb ? {~s[11], s[10:0]} : s;
    endfunction

    // R20 two-bit level codes
    assign pinRaw = {lnk.resetPin, lnk.selLvl, lnk.sclkLvl, lnk.dataPin, lnk.modePins};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinS1_r <= 9'h000;
            pinS2_r <= 9'h000;
        end else begin
            pinS1_r <= pinRaw;
            pinS2_r <= pinS1_r;
        end
    end

    assign rstPinD = pinS2_r[8];
    assign selD = pinS2_r[7:6];
    assign sclkD = pinS2_r[5:4];
    assign dataD = pinS2_r[3];
    assign modeD = pinS2_r[2:0];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclkPrev_r <= 1'b0;
            rstPrev_r <= 1'b0;
        end else begin
            sclkPrev_r <= sclkD[1];
            rstPrev_r <= rstPinD;
        end
    end

    // R15 falling shift clock edge
    assign sclkFall = sclkPrev_r & ~sclkD[1];
    // R8 reset pin edge loads defaults
    assign hwInit = rstPinD & ~rstPrev_r;
    assign serialMode = ~rstPinD;

    // R19 shift port closed while reset pin high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serState_r <= SER_OFF;
        end else begin
            unique case (serState_r)
                SER_OFF: begin
                    if (!rstPinD && !selD[1]) begin
                        serState_r <= SER_ACT;
                    end
                end
                SER_ACT: begin
                    if (rstPinD || selD[1]) begin
                        serState_r <= SER_OFF;
                    end
                end
                default: begin
                    serState_r <= SER_OFF;
                end
            endcase
        end
    end

    // R16 first bit in is address MSB
    assign wordNxt = {shift_r[14:0], dataD};
    // R15 commit on each sixteenth edge
    assign commit = (serState_r == SER_ACT) && !selD[1] && !rstPinD && sclkFall
        && (bitCnt_r == 4'(`ACMS_WORD_BITS - 1));

    // R15 counter restarts per select pulse, partial tail dropped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bitCnt_r <= 4'h0;
            shift_r <= 16'h0000;
        end else if (serState_r != SER_ACT || selD[1] || rstPinD) begin
            bitCnt_r <= 4'h0;
        end else if (sclkFall) begin
            bitCnt_r <= bitCnt_r + 4'h1;
            shift_r <= wordNxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrlReg_r <= `ACMS_CTRL_DEF;
            pwrReg_r <= `ACMS_PWR_DEF;
            cfgReg_r <= `ACMS_CFG_DEF;
        end else if (hwInit || ctrlReg_r[`ACMS_CTRL_SRST]) begin
            // R8 defaults on init, R17 soft bit clears itself here
            ctrlReg_r <= `ACMS_CTRL_DEF;
            pwrReg_r <= `ACMS_PWR_DEF;
            cfgReg_r <= `ACMS_CFG_DEF;
        end else if (commit) begin
            // R16 address byte selects, data byte stored
            unique case (wordNxt[15:8])
                `ACMS_DREG_CTRL: ctrlReg_r <= wordNxt[7:0];
                `ACMS_DREG_PWR: pwrReg_r <= wordNxt[7:0];
                `ACMS_DREG_CFG: cfgReg_r <= wordNxt[7:0];
                default: begin
                end
            endcase
        end
    end

    // R4 shift clock level decode
    assign {pinGain, pinExt} = lvlSplit(sclkD);
    // R5 select level decode
    assign {pinCmos, pinStraight} = lvlSplit(selD);

    always_comb begin
        if (rstPinD) begin
            // R3 pin mode follows levels continuously
            gainHigh = pinGain;
            extRef = pinExt;
            cmosIf = pinCmos;
            straightBin = pinStraight;
            lowLatency = 1'b0;
            // R6 three pins decoded jointly
            pwrMode = acms_pwr_t'(modeD);
        end else begin
            gainHigh = cfgReg_r[`ACMS_CFG_GAIN];
            extRef = cfgReg_r[`ACMS_CFG_EXTREF];
            cmosIf = cfgReg_r[`ACMS_CFG_CMOS];
            straightBin = cfgReg_r[`ACMS_CFG_STRAIGHT];
            lowLatency = ctrlReg_r[`ACMS_CTRL_LOWLAT];
            if (pwrReg_r[`ACMS_PWR_PIN_PRIORITY_SELECT]) begin
                // R14 register field overrides pins
                pwrMode = acms_pwr_t'(pwrReg_r[2:0]);
            end else begin
                // R13 R12 pins govern power modes
                pwrMode = acms_pwr_t'(modeD);
            end
        end
    end

    // Sample delay line; entry k holds the sample taken k+1 ticks ago
    always_ff @(posedge clk) begin
        if (sampleTick) begin
            pipeA[0] <= chanA;
            pipeB[0] <= chanB;
        end
    end

    for (genvar k = 1; k < `ACMS_LAT_LONG; k++) begin : g_pipe
        always_ff @(posedge clk) begin
            if (sampleTick) begin
                pipeA[k] <= pipeA[k-1];
                pipeB[k] <= pipeB[k-1];
            end
        end
    end

    // R1 tap chosen by latency option
    assign tapA = lowLatency ? pipeA[`ACMS_LAT_SHORT-1] : pipeA[`ACMS_LAT_LONG-1];
    assign tapB = lowLatency ? pipeB[`ACMS_LAT_SHORT-1] : pipeB[`ACMS_LAT_LONG-1];

    // R18 pattern effects on output buffers and power
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outA <= 12'h000;
            outB <= 12'h000;
            outValid <= 1'b0;
            outAEn <= 1'b0;
            outBEn <= 1'b0;
            muxPhase_r <= 1'b0;
        end else begin
            outValid <= sampleTick && (pwrMode != PWR_DOWN_AB);
            outAEn <= !(pwrMode inside {PWR_BUF_A_OFF, PWR_BUF_AB_OFF, PWR_DOWN_AB,
                PWR_STBY_A});
            outBEn <= !(pwrMode inside {PWR_BUF_B_OFF, PWR_BUF_AB_OFF, PWR_DOWN_AB,
                PWR_STBY_B, PWR_INTERLEAVED});
            if (sampleTick) begin
                muxPhase_r <= ~muxPhase_r;
                // Interleaved mode: A and B alternate on the A bus
                if (pwrMode == PWR_INTERLEAVED && muxPhase_r) begin
                    outA <= fmtConv(tapB, straightBin);
                end else begin
                    outA <= fmtConv(tapA, straightBin);
                end
                outB <= fmtConv(tapB, straightBin);
            end
        end
    end
endmodule

// File: hdl/acms_host.sv
// Host controller end: drives reset, level and serial pins from commands.
// Software uses a plain strobe port; read data arrive one cycle later.
`include "acms_defs.svh"
module acms_host
    import acms_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    acms_if.host lnk, // Configuration pins
    input wire logic [2:0] addr, // Command register address
    input wire logic [15:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [15:0] rdata // Read data, cycle after rd
);
    acms_hst_t st_r;
    logic [15:0] ctrl_r;
    logic [15:0] lvl_r;
    logic [15:0] word_r;
    logic [3:0] bitCnt_r;
    logic [7:0] halfCnt_r;
    logic [7:0] rstCnt_r;
    logic busy;
    logic halfDone;
    logic pinMode;

    assign busy = (st_r != HST_IDLE) || (rstCnt_r != 8'h00);
    assign halfDone = (halfCnt_r == 8'(`ACMS_SCLK_HALF_CYC - 1));
    assign pinMode = ctrl_r[`ACMS_HCTL_PINMODE];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `ACMS_HCTL_DEF;
            lvl_r <= `ACMS_HLVL_DEF;
        end else if (wr && addr == `ACMS_HREG_CTRL && !busy) begin
            ctrl_r <= wdata;
            ctrl_r[`ACMS_HCTL_RSTPULSE] <= 1'b0;
        end else if (wr && addr == `ACMS_HREG_LVL) begin
            lvl_r <= wdata;
        end
    end

    // R8 reset pin pulse, widened for the far synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstCnt_r <= 8'h00;
        end else if (wr && addr == `ACMS_HREG_CTRL && !busy
            && wdata[`ACMS_HCTL_RSTPULSE] && !wdata[`ACMS_HCTL_PINMODE]) begin
            rstCnt_r <= 8'(`ACMS_RST_CYC);
        end else if (rstCnt_r != 8'h00) begin
            rstCnt_r <= rstCnt_r - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= HST_IDLE;
            halfCnt_r <= 8'h00;
            bitCnt_r <= 4'h0;
            word_r <= 16'h0000;
        end else begin
            halfCnt_r <= (st_r == HST_IDLE || halfDone) ? 8'h00 : halfCnt_r + 8'h01;
            unique case (st_r)
                HST_IDLE: begin
                    // R7 frames only when reset pin is low
                    if (wr && addr == `ACMS_HREG_WORD && !busy && !pinMode) begin
                        word_r <= wdata;
                        bitCnt_r <= 4'h0;
                        st_r <= HST_SETUP;
                    end
                end
                HST_SETUP: begin
                    if (halfDone) begin
                        st_r <= HST_HI;
                    end
                end
                HST_HI: begin
                    if (halfDone) begin
                        st_r <= HST_LO;
                    end
                end
                HST_LO: begin
                    if (halfDone) begin
                        bitCnt_r <= bitCnt_r + 4'h1;
                        // R15 exactly sixteen falling edges per word
                        if (bitCnt_r == 4'hf) begin
                            // Last bit stays on the pin through the hold
                            st_r <= HST_HOLD;
                        end else begin
                            word_r <= {word_r[14:0], 1'b0};
                            st_r <= HST_HI;
                        end
                    end
                end
                HST_HOLD: begin
                    if (halfDone) begin
                        st_r <= HST_IDLE;
                    end
                end
                default: begin
                    st_r <= HST_IDLE;
                end
            endcase
        end
    end

    // R2 high in pin mode and during an R8 reset pulse, R9 R11 low otherwise
    assign lnk.resetPin = pinMode || (rstCnt_r != 8'h00);
    // R10 software writes zero mode pins for serial-only use
    assign lnk.modePins = ctrl_r[`ACMS_HCTL_MODE_LSB +: 3];
    assign lnk.selLvl = pinMode ? lvl_r[1:0]
        : ((st_r == HST_IDLE) ? `ACMS_LVL_HIGH : `ACMS_LVL_LOW);
    assign lnk.sclkLvl = pinMode ? lvl_r[3:2]
        : ((st_r == HST_HI) ? `ACMS_LVL_HIGH : `ACMS_LVL_LOW);
    // R16 address MSB leaves first
    assign lnk.dataPin = (st_r != HST_IDLE) && word_r[15];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            unique case (addr)
                `ACMS_HREG_CTRL: rdata <= ctrl_r;
                `ACMS_HREG_LVL: rdata <= lvl_r;
                `ACMS_HREG_WORD: rdata <= word_r;
                `ACMS_HREG_STAT: rdata <= {15'h0000, busy};
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule

// File: tb/acms_monitor.sv
// Checker for the link pins between the host end and the converter end.
// Assumes one clock for both ends; placed beside the joining interface.
`include "acms_defs.svh"
module acms_monitor (
    input wire logic clk, // System clock
    input wire logic rstn, // Reset, active low
    input wire logic resetPin, // Reset or pin-mode pin
    input wire logic [1:0] selLvl, // Serial select level code
    input wire logic [1:0] sclkLvl, // Shift clock level code
    input wire logic dataPin, // Serial data pin
    input wire logic [2:0] modePins // Mode pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic frame, sHi, sLo, fallEv, hiPrev_r;
    logic [4:0] falls_r;
    // Select low counts as a frame only while the reset pin is low
    assign frame = (selLvl == `ACMS_LVL_LOW) && !resetPin;
    assign sHi = sclkLvl == `ACMS_LVL_HIGH;
    assign sLo = sclkLvl == `ACMS_LVL_LOW;
    assign fallEv = frame && hiPrev_r && sLo;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hiPrev_r <= 1'b0;
        end else begin
            hiPrev_r <= sHi;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            falls_r <= 5'h0;
        end else if (!frame) begin
            falls_r <= 5'h0;
        end else if (hiPrev_r && !sHi) begin
            falls_r <= falls_r + 5'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence lowPhase;
        sLo [*4] ##1 sHi;
    endsequence
    sequence holdEnd;
        (sLo && frame) [*4] ##[1:5] !frame;
    endsequence
    reset_pulse_a: assert property ($rose(resetPin) |-> resetPin [*3])
        else $error("reset pin pulse too short");
    frame_setup_a: assert property ($rose(frame) |-> lowPhase)
        else $error("shift clock not low after select fell");
    high_phase_a: assert property (frame && $rose(sHi) |-> sHi [*4] ##1 (sLo && frame))
        else $error("shift clock high phase wrong");
    low_phase_a: assert property (fallEv && falls_r < 5'd15 |-> lowPhase)
        else $error("shift clock low phase wrong");
    frame_hold_a: assert property (fallEv && falls_r == 5'd15 |-> holdEnd)
        else $error("frame end hold wrong");
    bit_count_a: assert property ($fell(frame) |-> falls_r == 5'd16)
        else $error("frame did not carry sixteen falling edges");
    data_change_a: assert property (frame && $changed(dataPin) |-> $rose(frame) || $rose(sHi))
        else $error("data changed away from a rising shift clock");
    reset_quiet_a: assert property (frame ##1 (selLvl == `ACMS_LVL_LOW) |-> !resetPin)
        else $error("reset pin rose inside a frame");
endmodule

// File: tb/acms_bench.sv
// Bench joining host and converter ends; drives the host port and samples.
// Assumes the pin mode test comes last, since it never leaves pin mode.
`include "acms_defs.svh"
module acms_bench
    import acms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, sampleTick = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [11:0] chanA = 12'h000, chanB = 12'h000, outA, outB;
    logic outValid, outAEn, outBEn, gainHigh, extRef, cmosIf, straightBin, lowLatency;
    logic serialMode;
    acms_pwr_t pwrMode;
    logic [24:0] expQ[$];
    logic [24:0] e;
    logic [15:0] rv;
    int fail_count = 0, checks_done = 0;
    acms_if lnk();
    acms_host acms_host_inst(.clk(clk), .rstn(rstn), .lnk(lnk.host), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    acms_dev acms_dev_inst(.clk(clk), .rstn(rstn), .lnk(lnk.dev), .sampleTick(sampleTick),
        .chanA(chanA), .chanB(chanB), .outA(outA), .outB(outB), .outValid(outValid),
        .outAEn(outAEn), .outBEn(outBEn), .gainHigh(gainHigh), .extRef(extRef),
        .cmosIf(cmosIf), .straightBin(straightBin), .lowLatency(lowLatency),
        .serialMode(serialMode), .pwrMode(pwrMode));
    acms_monitor acms_monitor_inst(.clk(clk), .rstn(rstn), .resetPin(lnk.resetPin),
        .selLvl(lnk.selLvl), .sclkLvl(lnk.sclkLvl), .dataPin(lnk.dataPin),
        .modePins(lnk.modePins));
    always #5 clk = ~clk;
    task automatic results();
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic cmp_sample(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t sample got %h exp %h", $time, got, exp);
        end
    endtask
    // Order: gain, ref, cmos, straight, low latency, serial, power mode
    task automatic cfg_is(input logic [8:0] exp, input string msg);
        check({7'h00, gainHigh, extRef, cmosIf, straightBin, lowLatency, serialMode,
            pwrMode}, {7'h00, exp}, msg);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Pin levels cross a two-flop synchroniser, hence the settle
    task automatic ctrl(input logic pin, input logic pulse, input logic [2:0] m);
        wr_reg(`ACMS_HREG_CTRL, {11'h000, m, pulse, pin});
        settle(8);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_idle();
        int n;
        logic [15:0] st;
        n = 0;
        do begin
            rd_reg(`ACMS_HREG_STAT, st);
            n++;
        end while (st[0] !== 1'b0 && n < 100);
        check(16'(n < 100), 16'h0001, "busy stuck");
        settle(6);
    endtask
    task automatic dev_write(input logic [7:0] a, input logic [7:0] d);
        wr_reg(`ACMS_HREG_WORD, {a, d});
        wait_idle();
    endtask
    task automatic run_ticks(input int lat, input logic [11:0] msk);
        logic [11:0] ha[30];
        logic [11:0] hb[30];
        for (int k = 0; k < 30; k++) begin
            ha[k] = 12'($urandom);
            hb[k] = 12'($urandom);
            @(posedge clk);
            sampleTick <= 1'b1;
            chanA <= ha[k];
            chanB <= hb[k];
            if (k >= lat) begin
                expQ.push_back({1'b1, ha[k - lat] ^ msk, hb[k - lat] ^ msk});
            end else begin
                expQ.push_back(25'h000_0000);
            end
            @(posedge clk);
            sampleTick <= 1'b0;
            settle(2);
        end
        settle(4);
    endtask
    always @(posedge clk) begin
        if (outValid === 1'b1) begin
            if (expQ.size() == 0) begin
                check(16'h0000, 16'h0001, "extra sample");
            end else begin
                e = expQ.pop_front();
                if (e[24]) cmp_sample({outA, outB}, e[23:0]);
            end
        end
    end
    initial begin
        #200_000;
        fail_count++;
        results();
    end
    initial begin
        void'($urandom(32'hdd58_e102));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        settle(4);
        cfg_is(9'h008, "after reset");
        for (int m = 0; m < 8; m++) begin
            ctrl(1'b0, 1'b0, 3'(m));
            check({13'h0000, pwrMode}, 16'(m), "mode decode");
            check({14'h0000, outAEn, outBEn}, {14'h0000, !(m inside {1, 3, 4, 5}),
                !(m inside {2, 3, 4, 6, 7})}, "buffer enables");
        end
        // Serial only: mode pins held low
        ctrl(1'b0, 1'b0, 3'h0);
        dev_write(8'h02, 8'h0F);
        cfg_is(9'h1E8, "serial config");
        run_ticks(14, 12'h800);
        dev_write(8'h00, 8'h02);
        cfg_is(9'h1F8, "low latency");
        run_ticks(10, 12'h800);
        // Combined control: pins set, register override on
        ctrl(1'b0, 1'b0, 3'h5);
        dev_write(8'h01, 8'h0B);
        cfg_is(9'h1FB, "override one");
        dev_write(8'h00, 8'h01);
        cfg_is(9'h00D, "soft reset");
        dev_write(8'h02, 8'h01);
        cfg_is(9'h10D, "soft reset cleared");
        ctrl(1'b0, 1'b1, 3'h5);
        cfg_is(9'h00D, "reset pulse");
        rd_reg(`ACMS_HREG_CTRL, rv);
        check(rv, 16'h0014, "pulse bit self-clears");
        ctrl(1'b1, 1'b0, 3'h6);
        for (int c = 0; c < 4; c++) begin
            wr_reg(`ACMS_HREG_LVL, 16'(c * 5));
            settle(8);
            cfg_is({c[1], c[1] ^ c[0], c[1], c[1] ^ c[0], 5'h06}, "pin mode");
            rd_reg(`ACMS_HREG_LVL, rv);
            check(rv, 16'(c * 5), "level readback");
        end
        wr_reg(`ACMS_HREG_WORD, 16'h0200);
        settle(150);
        cfg_is(9'h146, "shift ignored");
        results();
    end
endmodule
